// [rtl/hpf_pkg.sv]
package hpf_pkg;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  localparam logic [7:0] PCI_OFS_STATUS = 8'h14;
  localparam logic [7:0] PCI_OFS_CMDVEC = 8'h18;
  localparam logic [7:0] PCI_OFS_DATA   = 8'h1c;
  localparam logic [2:0] BUS_IDX_STATUS = 3'h5;
  localparam logic [2:0] BUS_IDX_CMDVEC = 3'h6;
  localparam logic [2:0] BUS_IDX_DATA   = 3'h7;

  // ----------------------------------------------------------------
  // Host mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_PCI   = 3'h1;
  localparam logic [2:0] MODE_BUS_A = 3'h2;
  localparam logic [2:0] MODE_BUS_B = 3'h3;

  // ----------------------------------------------------------------
  // FIFO depths and wait limit
  // ----------------------------------------------------------------
  localparam int         TX_DEPTH      = 6;
  localparam int         RX_DEPTH      = 6;
  localparam logic [2:0] TX_CAP_FULL   = 3'h6;
  localparam logic [2:0] TX_CAP_BUS    = 3'h5;
  localparam logic [2:0] TX_CAP_PCI32  = 3'h3;
  localparam logic [2:0] RX_CAP        = 3'h6;
  localparam logic [2:0] PTR_LAST      = 3'h5;
  localparam logic [3:0] PCI_MAX_WAITS = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          STAT_REQ     = 7;
  localparam int          STAT_RXREQ   = 2;
  localparam int          STAT_TXREQ   = 1;
  localparam int          STAT_TXRDY   = 0;
  localparam int          CV_PEND      = 0;
  localparam logic [31:0] CV_WMASK     = 32'h0000_80ff;
  localparam logic [31:0] BUS_WMASK    = 32'h00ff_ffff;
  localparam logic [31:0] CV_RESET     = 32'h0000_0000;
  localparam logic        TXRDY_RESET  = 1'b1;

  // Host access as presented by the bus front end
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } hpf_host_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} hpf_state_t;

endpackage

// [rtl/hpf_status.sv]
module hpf_status (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Mode and enables
  input  wire logic [2:0]            host_mode_field,
  input  wire logic [1:0]            tx_format_field,
  input  wire logic                  slave_fetch_type,
  input  wire logic                  rx_request_enable,
  input  wire logic                  tx_request_enable,
  // Host access
  input  wire hpf_pkg::hpf_host_req_t host_req,
  output logic [31:0]                host_rdata_q,
  output logic                       pci_target_ready_pin_q,
  output logic                       transfer_ack_pin_q,
  output logic                       host_retry_q,
  output logic                       host_irq_pin_q,
  // Core transmit register into the receive FIFO
  input  wire logic                  core_tx_valid,
  input  wire logic [31:0]           core_tx_data,
  output logic                       core_tx_ready_q,
  // Core receive register out of the transmit FIFO
  input  wire logic                  core_rx_pop,
  output logic [31:0]                core_rx_data_q,
  output logic                       core_rx_valid_q,
  // Host command handshake
  input  wire logic                  core_cmd_done,
  output logic [31:0]                cmd_vector_q
);

  // ----------------------------------------------------------------
  // Mode and address decode
  // ----------------------------------------------------------------
  wire logic       is_pci   = host_mode_field == hpf_pkg::MODE_PCI;
  wire logic       is_bus   = host_mode_field == hpf_pkg::MODE_BUS_A ||
                              host_mode_field == hpf_pkg::MODE_BUS_B;
  wire logic [2:0] bus_idx  = host_req.addr[2:0];
  wire logic       hit_stat = is_pci ? host_req.addr == hpf_pkg::PCI_OFS_STATUS
                                     : bus_idx == hpf_pkg::BUS_IDX_STATUS;
  wire logic       hit_cmd  = is_pci ? host_req.addr == hpf_pkg::PCI_OFS_CMDVEC
                                     : bus_idx == hpf_pkg::BUS_IDX_CMDVEC;
  wire logic       hit_data = is_pci ? host_req.addr == hpf_pkg::PCI_OFS_DATA
                                     : bus_idx == hpf_pkg::BUS_IDX_DATA;

  // Usable depth shrinks with the mode; a deeper fill left over from a mode change just
  // reads as full until it drains
  wire logic [2:0] tx_cap = is_bus ? hpf_pkg::TX_CAP_BUS
                          : (is_pci && tx_format_field == 2'h0) ? hpf_pkg::TX_CAP_PCI32
                          : hpf_pkg::TX_CAP_FULL;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hpf_pkg::hpf_state_t st_q, st_d;
  logic [3:0]  wait_q, wait_d;
  logic [2:0]  tx_cnt_q, tx_rd_q, tx_wr_q;
  logic [2:0]  rx_cnt_q, rx_rd_q, rx_wr_q;
  logic [31:0] tx_mem [hpf_pkg::TX_DEPTH];
  logic [31:0] rx_mem [hpf_pkg::RX_DEPTH];
  logic        rx_flag_q, tx_flag_q, txrdy_q, combined_host_request_q;

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  wire logic rx_avail  = rx_cnt_q != 3'h0;
  wire logic tx_room   = tx_cnt_q < tx_cap;
  wire logic cmd_busy  = cmd_vector_q[hpf_pkg::CV_PEND];
  wire logic ready_now = host_req.wr ? ((hit_data ? tx_room : 1'b1) &&
                                        !(hit_cmd && cmd_busy))
                                     : (hit_data ? rx_avail : 1'b1);
  wire logic req_live  = host_req.sel && (is_pci || is_bus) &&
                         (st_q == hpf_pkg::ST_IDLE || st_q == hpf_pkg::ST_WAIT);
  wire logic finish    = req_live && ready_now;
  // Only PCI gives up; the parallel bus waits as long as it takes
  wire logic give_up   = req_live && !ready_now && is_pci && st_q == hpf_pkg::ST_WAIT &&
                         wait_q == hpf_pkg::PCI_MAX_WAITS - 4'h1;
  wire logic tx_push   = finish && host_req.wr && hit_data;
  wire logic rx_pop    = finish && !host_req.wr && hit_data;
  wire logic cmd_wr    = finish && host_req.wr && hit_cmd;
  wire logic tx_pop    = core_rx_pop && tx_cnt_q != 3'h0;
  wire logic rx_push   = core_tx_valid && rx_cnt_q < hpf_pkg::RX_CAP;

  // Next state of the access sequencer
  always_comb
  begin
    st_d   = st_q;
    wait_d = wait_q;
    case (st_q)
      hpf_pkg::ST_IDLE:
      begin
        wait_d = 4'h0;
        if (finish)
          st_d = hpf_pkg::ST_DONE;
        else if (req_live)
          st_d = hpf_pkg::ST_WAIT;
      end
      hpf_pkg::ST_WAIT:
      begin
        if (finish || give_up || !host_req.sel)
          st_d = hpf_pkg::ST_DONE;
        else
          wait_d = wait_q + 4'h1;
      end
      hpf_pkg::ST_DONE:
      begin
        // Host must drop its select before a new access is looked at
        if (!host_req.sel)
          st_d = hpf_pkg::ST_IDLE;
      end
      default: st_d = hpf_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // FIFO counts and pointers
  // ----------------------------------------------------------------
  wire logic [2:0] tx_cnt_d = tx_cnt_q + {2'b00, tx_push} - {2'b00, tx_pop};
  wire logic [2:0] rx_cnt_d = rx_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
  wire logic [2:0] tx_rd_d  = tx_pop ? (tx_rd_q == hpf_pkg::PTR_LAST ? 3'h0 : tx_rd_q + 3'h1)
                                     : tx_rd_q;
  wire logic [2:0] tx_wr_d  = tx_push ? (tx_wr_q == hpf_pkg::PTR_LAST ? 3'h0 : tx_wr_q + 3'h1)
                                      : tx_wr_q;
  wire logic [2:0] rx_rd_d  = rx_pop ? (rx_rd_q == hpf_pkg::PTR_LAST ? 3'h0 : rx_rd_q + 3'h1)
                                     : rx_rd_q;
  wire logic [2:0] rx_wr_d  = rx_push ? (rx_wr_q == hpf_pkg::PTR_LAST ? 3'h0 : rx_wr_q + 3'h1)
                                      : rx_wr_q;

  // Head of the host-to-core FIFO is the core receive register; a word landing in an
  // empty (or just emptied) FIFO is forwarded in the same cycle
  wire logic        tx_fwd    = tx_cnt_q == 3'h0 || (tx_pop && tx_cnt_q == 3'h1);
  wire logic [31:0] tx_wdata  = is_bus ? host_req.wdata & hpf_pkg::BUS_WMASK : host_req.wdata;
  wire logic [31:0] core_rx_d = tx_cnt_d == 3'h0 ? 32'h0000_0000
                              : tx_fwd ? tx_wdata : tx_mem[tx_rd_d];

  // Flags from the next counts, so they track every transfer in the same edge
  wire logic rx_flag_d = !slave_fetch_type && rx_cnt_d != 3'h0;
  wire logic tx_flag_d = tx_cnt_d < tx_cap;
  wire logic txrdy_d   = tx_cnt_d == 3'h0;
  wire logic combined_host_request_d    = (tx_request_enable && tx_flag_d) ||
                         (rx_request_enable && rx_flag_d);

  // Read data; status reads touch nothing
  wire logic [31:0] status_w = {24'h00_0000, combined_host_request_q, 4'h0, rx_flag_q, tx_flag_q, txrdy_q};
  wire logic [31:0] rdata_w  = hit_stat ? status_w
                             : hit_cmd  ? cmd_vector_q
                             : hit_data ? rx_mem[rx_rd_q] : 32'h0000_0000;

  // Byte-lane merge for command vector writes
  wire logic [31:0] lane_mask = {{8{host_req.be[3]}}, {8{host_req.be[2]}},
                                 {8{host_req.be[1]}}, {8{host_req.be[0]}}};
  wire logic [31:0] cv_wmask  = lane_mask & hpf_pkg::CV_WMASK;
  wire logic [31:0] cv_d      = (cmd_vector_q & ~cv_wmask) | (host_req.wdata & cv_wmask);

  // ----------------------------------------------------------------
  // FIFO storage, one generate loop per FIFO
  // ----------------------------------------------------------------
  for (genvar i = 0; i < hpf_pkg::TX_DEPTH; i++)
  begin : g_tx
    always_ff @(posedge ref_clk)
    begin
      if (tx_push && tx_wr_q == 3'(i))
        tx_mem[i] <= tx_wdata;
    end
  end

  for (genvar i = 0; i < hpf_pkg::RX_DEPTH; i++)
  begin : g_rx
    always_ff @(posedge ref_clk)
    begin
      if (rx_push && rx_wr_q == 3'(i))
        rx_mem[i] <= core_tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sequencer and FIFO bookkeeping
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_q     <= hpf_pkg::ST_IDLE;
      wait_q   <= 4'h0;
      tx_cnt_q <= 3'h0;
      tx_rd_q  <= 3'h0;
      tx_wr_q  <= 3'h0;
      rx_cnt_q <= 3'h0;
      rx_rd_q  <= 3'h0;
      rx_wr_q  <= 3'h0;
    end
    else
    begin
      st_q     <= st_d;
      wait_q   <= wait_d;
      tx_cnt_q <= tx_cnt_d;
      tx_rd_q  <= tx_rd_d;
      tx_wr_q  <= tx_wr_d;
      rx_cnt_q <= rx_cnt_d;
      rx_rd_q  <= rx_rd_d;
      rx_wr_q  <= rx_wr_d;
    end
  end

  // Flags and outputs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rx_flag_q              <= 1'b0;
      tx_flag_q              <= 1'b0;
      txrdy_q                <= hpf_pkg::TXRDY_RESET;
      combined_host_request_q                 <= 1'b0;
      host_irq_pin_q         <= 1'b0;
      host_rdata_q           <= 32'h0000_0000;
      pci_target_ready_pin_q <= 1'b0;
      transfer_ack_pin_q     <= 1'b0;
      host_retry_q           <= 1'b0;
      core_tx_ready_q        <= 1'b0;
      core_rx_data_q         <= 32'h0000_0000;
      core_rx_valid_q        <= 1'b0;
    end
    else
    begin
      rx_flag_q              <= rx_flag_d;
      tx_flag_q              <= tx_flag_d;
      txrdy_q                <= txrdy_d;
      combined_host_request_q                 <= combined_host_request_d;
      host_irq_pin_q         <= combined_host_request_d;
      host_rdata_q           <= (finish && !host_req.wr) ? rdata_w : host_rdata_q;
      pci_target_ready_pin_q <= finish && is_pci;
      transfer_ack_pin_q     <= finish && is_bus;
      host_retry_q           <= give_up;
      core_tx_ready_q        <= rx_cnt_d < hpf_pkg::RX_CAP;
      core_rx_data_q         <= core_rx_d;
      core_rx_valid_q        <= tx_cnt_d != 3'h0;
    end
  end

  // Command vector; only accepted while idle, so the core's done never races a write
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cmd_vector_q <= hpf_pkg::CV_RESET;
    else if (cmd_wr)
      cmd_vector_q <= cv_d;
    else if (core_cmd_done)
      cmd_vector_q[hpf_pkg::CV_PEND] <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fetch_zero: assert property (@(posedge ref_clk) disable iff (srst)
    slave_fetch_type |=> !rx_flag_q)
    else $error("receive flag set in fetch mode");

  chk_rx_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
    (rx_push && !slave_fetch_type) |=> rx_flag_q)
    else $error("receive flag not set after core data");

  chk_txrdy_write: assert property (@(posedge ref_clk) disable iff (srst)
    tx_push |=> !txrdy_q ##0 core_rx_valid_q)
    else $error("transmitter ready still set after host write");

  chk_irq_combine: assert property (@(posedge ref_clk) disable iff (srst)
    host_irq_pin_q == (($past(tx_request_enable) && tx_flag_q) ||
                       ($past(rx_request_enable) && rx_flag_q)))
    else $error("interrupt does not match enabled flags");

  chk_pci_wait_max: assert property (@(posedge ref_clk) disable iff (srst)
    (is_pci && req_live && !ready_now && st_q == hpf_pkg::ST_IDLE) ##1
    (st_q == hpf_pkg::ST_WAIT && is_pci && host_req.sel)[*8] |=>
    (pci_target_ready_pin_q || host_retry_q))
    else $error("pci access ran past eight wait cycles");

  chk_bus_rd_stall: assert property (@(posedge ref_clk) disable iff (srst)
    (is_bus && req_live && !host_req.wr && hit_data && !rx_avail) |=> !transfer_ack_pin_q)
    else $error("bus read acknowledged with no receive data");

  chk_bus_wr_stall: assert property (@(posedge ref_clk) disable iff (srst)
    (is_bus && req_live && host_req.wr && hit_data && !tx_room) |=> !transfer_ack_pin_q)
    else $error("bus write acknowledged into a full fifo");

  chk_cmd_stall: assert property (@(posedge ref_clk) disable iff (srst)
    (req_live && host_req.wr && hit_cmd && cmd_busy) |=>
    !(transfer_ack_pin_q || pci_target_ready_pin_q))
    else $error("command write taken while a command is pending");

  chk_tx_depth: assert property (@(posedge ref_clk) disable iff (srst)
    tx_push |-> tx_cnt_q < tx_cap)
    else $error("host write beyond the mode depth");

endmodule // hpf_status

// [testbench/hpf_host_model.sv]
// ----------------------------------------------------------------
// Host master that owns the request struct
// ----------------------------------------------------------------
module hpf_host_model (
  // Clock
  input  wire logic                   ref_clk,
  // Host request and answers
  output hpf_pkg::hpf_host_req_t      host_req,
  input  wire logic                   pci_target_ready_pin_q,
  input  wire logic                   transfer_ack_pin_q,
  input  wire logic                   host_retry_q,
  input  wire logic [31:0]            host_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host_req = '0;

  // Hold the request until an answer shows or 40 cycles pass, then release the bus
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                        output logic [1:0] resp, output logic [31:0] rd, output int cyc);
    resp = 2'h0;
    cyc = 0;
    host_req = '{sel: 1'b1, wr: wr, addr: addr, be: 4'hf, wdata: wd};
    while (resp == 2'h0 && cyc < 40)
    begin
      @(posedge ref_clk);
      #1;
      cyc++;
      if (pci_target_ready_pin_q === 1'b1 || transfer_ack_pin_q === 1'b1)
        resp = 2'h1;
      else if (host_retry_q === 1'b1)
        resp = 2'h2;
    end
    rd = host_rdata_q;
    // Released lines show the inverse so a stale value never looks valid
    host_req = '{sel: 1'b0, wr: ~wr, addr: ~addr, be: 4'h0, wdata: ~wd};
    // Select must be seen low for one edge before the next access
    @(posedge ref_clk);
    #1;
  endtask

endmodule // hpf_host_model

// [testbench/host_port_data_flow_status_tb.sv]
module host_port_data_flow_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus, design outputs and bookkeeping
  // ----------------------------------------------------------------
  logic                   ref_clk;
  logic                   srst;
  logic [2:0]             host_mode_field;
  logic [1:0]             tx_format_field;
  logic                   slave_fetch_type;
  logic                   rx_request_enable;
  logic                   tx_request_enable;
  hpf_pkg::hpf_host_req_t host_req;
  logic [31:0]            host_rdata_q;
  logic                   pci_target_ready_pin_q;
  logic                   transfer_ack_pin_q;
  logic                   host_retry_q;
  logic                   host_irq_pin_q;
  logic                   core_tx_valid;
  logic [31:0]            core_tx_data;
  logic                   core_tx_ready_q;
  logic                   core_rx_pop;
  logic [31:0]            core_rx_data_q;
  logic                   core_rx_valid_q;
  logic                   core_cmd_done;
  logic [31:0]            cmd_vector_q;
  int                     mismatches;
  int                     comparisons;
  logic [1:0]             resp;
  logic [31:0]            rdat;
  int                     cyc;

  // Bus mode uses a small index, PCI a byte offset; the bus data address is fixed because a
  // mode change and the access after it share one time step, before a wire could follow
  localparam logic [7:0] BUS_DATA = {5'h00, hpf_pkg::BUS_IDX_DATA};
  wire logic             bus_mode = host_mode_field != hpf_pkg::MODE_PCI;
  wire logic [7:0]       a_st     = bus_mode ? {5'h00, hpf_pkg::BUS_IDX_STATUS}
                                             : hpf_pkg::PCI_OFS_STATUS;

  hpf_status i_dut (.ref_clk, .srst, .host_mode_field, .tx_format_field, .slave_fetch_type,
    .rx_request_enable, .tx_request_enable, .host_req, .host_rdata_q, .pci_target_ready_pin_q,
    .transfer_ack_pin_q, .host_retry_q, .host_irq_pin_q, .core_tx_valid, .core_tx_data,
    .core_tx_ready_q, .core_rx_pop, .core_rx_data_q, .core_rx_valid_q, .core_cmd_done,
    .cmd_vector_q);

  hpf_host_model i_host (.ref_clk, .host_req, .pci_target_ready_pin_q, .transfer_ack_pin_q,
    .host_retry_q, .host_rdata_q);

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // An access that never completes ends the run
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    i_host.access(wr, a, wd, resp, rdat, cyc);
    if (resp == 2'h0)
    begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic st(input logic [31:0] exp);
    @(posedge ref_clk);
    #1;
    xfer(1'b0, a_st, 32'h0);
    check(rdat, exp);
  endtask

  task automatic pop_chk(input logic [31:0] exp);
    check({31'h0, core_rx_valid_q}, 32'h1);
    check(core_rx_data_q, exp);
    core_rx_pop = 1'b1;
    @(posedge ref_clk);
    #1;
    // An edge passes with the pop low, so back-to-back calls never retoggle it in one step
    core_rx_pop = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic push(input logic [31:0] d);
    core_tx_valid = 1'b1;
    core_tx_data = d;
    @(posedge ref_clk);
    #1;
    core_tx_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({31'h0, host_irq_pin_q}, 32'h0);
    st(32'h3);
    st(32'h3);
    xfer(1'b0, 8'h00, 32'h0);
    check(rdat, 32'h0);
    xfer(1'b0, hpf_pkg::PCI_OFS_CMDVEC, 32'h0);
    check(rdat, hpf_pkg::CV_RESET);
    $display("test reset done");
  endtask

  task automatic t_irq();
    tx_request_enable = 1'b1;
    st(32'h83);
    check({31'h0, host_irq_pin_q}, 32'h1);
    tx_request_enable = 1'b0;
    rx_request_enable = 1'b1;
    st(32'h3);
    check({31'h0, host_irq_pin_q}, 32'h0);
    rx_request_enable = 1'b0;
    $display("test irq done");
  endtask

  // Fill the host-to-core path without waits, overrun it, then drain in order
  task automatic t_pci_tx(input logic [1:0] fmt, input int n);
    tx_format_field = fmt;
    for (int i = 0; i < n; i++)
    begin
      xfer(1'b1, hpf_pkg::PCI_OFS_DATA, 32'ha500_0000 + i);
      check(cyc, 32'h1);
    end
    st(32'h0);
    xfer(1'b1, hpf_pkg::PCI_OFS_DATA, 32'h0);
    check(resp, 2'h2);
    check(cyc, 32'h9);
    for (int i = 0; i < n; i++)
      pop_chk(32'ha500_0000 + i);
    st(32'h3);
    $display("test pci tx done");
  endtask

  // Sixth write stalls until the core frees a slot
  task automatic t_bus_tx();
    host_mode_field = hpf_pkg::MODE_BUS_A;
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, BUS_DATA, 32'h100 + i);
      check(cyc, 32'h1);
    end
    fork
      xfer(1'b1, BUS_DATA, 32'h105);
      begin
        repeat (5) @(posedge ref_clk);
        #1;
        pop_chk(32'h100);
      end
    join
    check(resp, 2'h1);
    check({31'h0, cyc >= 6}, 32'h1);
    for (int i = 1; i < 6; i++)
      pop_chk(32'h100 + i);
    $display("test bus tx done");
  endtask

  task automatic t_rx();
    host_mode_field = hpf_pkg::MODE_PCI;
    xfer(1'b0, hpf_pkg::PCI_OFS_DATA, 32'h0);
    check(resp, 2'h2);
    check(cyc, 32'h9);
    push(32'h1234_5678);
    st(32'h7);
    rx_request_enable = 1'b1;
    st(32'h87);
    check({31'h0, host_irq_pin_q}, 32'h1);
    rx_request_enable = 1'b0;
    slave_fetch_type = 1'b1;
    st(32'h3);
    slave_fetch_type = 1'b0;
    xfer(1'b0, hpf_pkg::PCI_OFS_DATA, 32'h0);
    check(rdat, 32'h1234_5678);
    st(32'h3);
    host_mode_field = hpf_pkg::MODE_BUS_B;
    fork
      xfer(1'b0, BUS_DATA, 32'h0);
      begin
        repeat (5) @(posedge ref_clk);
        #1;
        push(32'h00ab_cdef);
      end
    join
    check(resp, 2'h1);
    check({31'h0, cyc >= 6}, 32'h1);
    check(rdat, 32'h00ab_cdef);
    $display("test rx done");
  endtask

  // Overfill the core-to-host FIFO, then read it back in order; the extra word is dropped
  task automatic t_rx_full();
    host_mode_field = hpf_pkg::MODE_PCI;
    core_tx_valid = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      core_tx_data = 32'hc000_0000 + i;
      @(posedge ref_clk);
      #1;
    end
    core_tx_valid = 1'b0;
    check({31'h0, core_tx_ready_q}, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, hpf_pkg::PCI_OFS_DATA, 32'h0);
      check(rdat, 32'hc000_0000 + i);
    end
    st(32'h3);
    check({31'h0, core_tx_ready_q}, 32'h1);
    $display("test rx full done");
  endtask

  // A pending command holds off the next command write
  task automatic t_cmd();
    host_mode_field = hpf_pkg::MODE_PCI;
    xfer(1'b1, hpf_pkg::PCI_OFS_CMDVEC, 32'h0000_8003);
    check(cmd_vector_q, 32'h8003);
    xfer(1'b1, hpf_pkg::PCI_OFS_CMDVEC, 32'h5);
    check(resp, 2'h2);
    core_cmd_done = 1'b1;
    @(posedge ref_clk);
    #1;
    core_cmd_done = 1'b0;
    xfer(1'b0, hpf_pkg::PCI_OFS_CMDVEC, 32'h0);
    check(rdat, 32'h8002);
    xfer(1'b1, hpf_pkg::PCI_OFS_CMDVEC, 32'h5);
    check(resp, 2'h1);
    $display("test cmd done");
  endtask

  initial
  begin
    srst = 1'b1;
    host_mode_field = hpf_pkg::MODE_PCI;
    tx_format_field = 2'h1;
    slave_fetch_type = 1'b0;
    rx_request_enable = 1'b0;
    tx_request_enable = 1'b0;
    core_tx_valid = 1'b0;
    core_tx_data = 32'h0;
    core_rx_pop = 1'b0;
    core_cmd_done = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_irq();
    t_pci_tx(2'h1, 6);
    t_pci_tx(2'h0, 3);
    t_bus_tx();
    t_rx();
    t_rx_full();
    t_cmd();
    conclude();
  end

endmodule // host_port_data_flow_status_tb
